// ### verilog/srsup_pkg.sv
// constants and carrier types for the supply reset supervisor
package srsup_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned CLK_PERIOD_NS = 40;
   // glitch rejection on the manual reset input, in ns
   localparam int unsigned MR_GLITCH_NS = 100;
   // guaranteed manual pulse width, in us
   localparam int unsigned MR_PULSE_MIN_US = 10;
   // supply indication glitch rejection, in us
   localparam int unsigned SUP_GLITCH_US = 20;
   // hold timeout, in ms: least, typical, most
   localparam int unsigned HOLD_MIN_MS = 100;
   localparam int unsigned HOLD_TYP_MS = 190;
   localparam int unsigned HOLD_MAX_MS = 560;
   // glitch times round up to whole cycles, plus one for the manual input; the hold uses the typical time
   localparam int unsigned MR_FILT_CYC = (MR_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int unsigned SUP_FILT_CYC = SUP_GLITCH_US * (CLK_HZ / 1000000);
   localparam int unsigned HOLD_CYC = HOLD_TYP_MS * (CLK_HZ / 1000);
   localparam int unsigned FILT_W = 10;
   localparam int unsigned HOLD_W = 23;
   // trip level options in 10 mV steps
   localparam logic [8:0] TRIP_HIGH = 9'h1cf;
   localparam logic [8:0] TRIP_MID = 9'h134;
   localparam logic [8:0] TRIP_LOW = 9'h0e8;
   localparam logic [8:0] TRIP_FLOOR = 9'h0dc;
   localparam logic [8:0] TRIP_CEIL = 9'h1f4;
   localparam logic [1:0] SYNC_IDLE = 2'h3;
   localparam logic [1:0] SYNC_LOW = 2'h0;

   typedef struct packed {
      logic supply_low;
      logic manual_reset_n;
   } srsup_in_t;

   typedef enum logic [1:0] {
      SRSUP_HOLD,
      SRSUP_TIMING,
      SRSUP_RUN
   } srsup_state_t;
endpackage

// ### verilog/srsup_filter.sv
// synchroniser and glitch filter for one level of either polarity
`timescale 1ns/1ps
module srsup_filter
   import srsup_pkg::*;
#(
   parameter int unsigned FILT_CYC = 4,
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_level,
   output logic o_level
);
   logic sync1_q;
   logic sync2_q;
   logic [FILT_W-1:0] cnt_q;
   logic [FILT_W-1:0] cnt_d;
   logic out_d;
   wire logic differs;
   wire logic settled;

   // two stages before any decision
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         sync1_q <= RESET_VAL;
         sync2_q <= RESET_VAL;
      end else begin
         sync1_q <= i_level;
         sync2_q <= sync1_q;
      end
   end

   assign differs = sync2_q != o_level;
   assign settled = cnt_q == FILT_W'(FILT_CYC - 1);

   // a change must hold for the filter time before it passes
   always_comb begin
      cnt_d = '0;
      out_d = o_level;
      if (differs) begin
         cnt_d = cnt_q + FILT_W'(1);
         if (settled) begin
            out_d = sync2_q;
            cnt_d = '0;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         cnt_q <= '0;
         o_level <= RESET_VAL;
      end else begin
         cnt_q <= cnt_d;
         o_level <= out_d;
      end
   end

   chk_filter_settle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $changed(o_level) |->
      $past(cnt_q) == FILT_W'(FILT_CYC - 1) && $past(sync2_q) != $past(o_level))
      else $error("filter output changed before the filter time");
endmodule

// ### verilog/srsup_top.sv
// supply reset supervisor: supply and manual reset to system reset
// Operation
// - reset asserts while supply indication is below the trip level, brownouts included.
// - after supply recovers, timer runs; reset releases only after full timeout.
// - push-pull reset output polarity is active-low or active-high by build parameter; open-drain always pulls low.
// - open-drain option drives low only when asserted, releases otherwise.
// - manual reset low beyond glitch interval asserts reset; shorter pulses ignored.
// - reset held while manual input low, then for full timeout after release.
// - manual input is debounced; unconnected input reads high.
// - short glitches on supply or manual input cause no reset.
// - trip level chosen at build time; three standard or 10 mV steps.
// - timeout lasts between 100 ms and 560 ms, typically 190 ms.
`timescale 1ns/1ps
module srsup_top
   import srsup_pkg::*;
#(
   parameter logic ACTIVE_HIGH = 1'b0,
   parameter logic OPEN_DRAIN = 1'b0,
   parameter logic [8:0] TRIP_LEVEL = TRIP_MID,
   parameter int unsigned HOLD_CYCLES = HOLD_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_supply_low,
   input wire logic i_manual_reset_n,
   output logic o_reset,
   output logic o_reset_oe,
   output logic [8:0] o_trip_level
);
   srsup_in_t in_w;
   logic sup_low_f;
   logic mr_n_f;
   srsup_state_t state_q;
   srsup_state_t state_d;
   logic [HOLD_W-1:0] hold_q;
   logic [HOLD_W-1:0] hold_d;
   wire logic cause;
   wire logic hold_done;
   wire logic assert_rst;
   logic [HOLD_W-1:0] quiet_q;

   // the level is constant, only the out-of-range case falls back
   function automatic logic [8:0] trip_pick(input logic [8:0] lvl);
      if (lvl < TRIP_FLOOR || lvl > TRIP_CEIL) begin
         return TRIP_MID;
      end
      return lvl;
   endfunction

   assign in_w = '{
      supply_low: i_supply_low,
      manual_reset_n: i_manual_reset_n
   };

   // power-on counts as supply low until the filter sees it good
   srsup_filter #(
      .FILT_CYC(SUP_FILT_CYC),
      .RESET_VAL(1'b1)
   ) u_sup_filt (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_level(in_w.supply_low),
      .o_level(sup_low_f)
   );

   // open input is high, filter resets to idle level
   srsup_filter #(
      .FILT_CYC(MR_FILT_CYC),
      .RESET_VAL(1'b1)
   ) u_mr_filt (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_level(in_w.manual_reset_n),
      .o_level(mr_n_f)
   );

   assign cause = sup_low_f || !mr_n_f;
   assign hold_done = hold_q == HOLD_W'(HOLD_CYCLES - 1);

   always_comb begin
      state_d = state_q;
      hold_d = hold_q;
      case (state_q)
         SRSUP_HOLD: begin
            hold_d = '0;
            if (!cause) begin
               state_d = SRSUP_TIMING;
            end
         end
         SRSUP_TIMING: begin
            hold_d = hold_q + HOLD_W'(1);
            if (cause) begin
               state_d = SRSUP_HOLD;
               hold_d = '0;
            end else if (hold_done) begin
               state_d = SRSUP_RUN;
               hold_d = '0;
            end
         end
         SRSUP_RUN: begin
            hold_d = '0;
            if (cause) begin
               state_d = SRSUP_HOLD;
            end
         end
         default: begin
            state_d = SRSUP_HOLD;
            hold_d = '0;
         end
      endcase
   end

   assign assert_rst = state_d != SRSUP_RUN;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         state_q <= SRSUP_HOLD;
         hold_q <= '0;
         o_reset <= ACTIVE_HIGH && !OPEN_DRAIN;
         o_reset_oe <= 1'b1;
         o_trip_level <= '0;
      end else begin
         state_q <= state_d;
         hold_q <= hold_d;
         o_reset <= OPEN_DRAIN ? 1'b0 : (assert_rst ~^ ACTIVE_HIGH);
         o_reset_oe <= OPEN_DRAIN ? assert_rst : 1'b1;
         o_trip_level <= trip_pick(TRIP_LEVEL);
      end
   end

   // quiet cycles since the last cause, counted apart from the hold timer
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n || cause || state_q == SRSUP_RUN) begin
         quiet_q <= '0;
      end else begin
         quiet_q <= quiet_q + HOLD_W'(1);
      end
   end

   // checks on the reset decision
   chk_reset_on_cause: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      cause |=> (o_reset_oe && (o_reset == (ACTIVE_HIGH && !OPEN_DRAIN))))
      else $error("reset not asserted on cause");

   chk_brownout_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      sup_low_f |=> state_q == SRSUP_HOLD)
      else $error("supply low did not hold reset");

   chk_state_legal: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      state_q inside {SRSUP_HOLD, SRSUP_TIMING, SRSUP_RUN})
      else $error("state out of range");

   chk_manual_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !mr_n_f |=> state_q == SRSUP_HOLD)
      else $error("manual low did not hold reset");

   chk_manual_release: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ($rose(mr_n_f) && !sup_low_f) |=> state_q == SRSUP_TIMING)
      else $error("manual release did not start timer");

   // checks on the hold timer
   chk_timeout_restart: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_q == SRSUP_TIMING && cause) |=> state_q == SRSUP_HOLD && hold_q == '0)
      else $error("timer not restarted");

   chk_hold_start: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(state_q == SRSUP_TIMING) |-> hold_q == '0)
      else $error("timer did not start from zero");

   chk_hold_steps: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_q == SRSUP_TIMING && $past(state_q) == SRSUP_TIMING) |->
      hold_q == $past(hold_q) + HOLD_W'(1))
      else $error("timer skipped a count");

   chk_timeout_length: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(state_q == SRSUP_RUN) |->
      $past(state_q) == SRSUP_TIMING && $past(hold_q) == HOLD_W'(HOLD_CYCLES - 1))
      else $error("release before full timeout");

   chk_release_span: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(state_q == SRSUP_RUN) |-> quiet_q == HOLD_W'(HOLD_CYCLES + 1))
      else $error("release span differs from timeout");

   // checks on the pin
   chk_open_drain_high: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      OPEN_DRAIN |-> !o_reset)
      else $error("open drain drove high");

   chk_pushpull_enable: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !OPEN_DRAIN |-> o_reset_oe)
      else $error("push-pull enable dropped");

   chk_output_state: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      OPEN_DRAIN ? (o_reset_oe == (state_q != SRSUP_RUN)) :
      (o_reset == ((state_q != SRSUP_RUN) ~^ ACTIVE_HIGH)))
      else $error("reset pin does not follow state");

   chk_release_run: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_q == SRSUP_RUN && !cause) |=>
      (OPEN_DRAIN ? !o_reset_oe : o_reset == !ACTIVE_HIGH))
      else $error("reset asserted without cause");

   // checks on the input filters
   chk_mr_glitch_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_q == SRSUP_RUN && !sup_low_f && $fell(mr_n_f)) |->
      $past(in_w.manual_reset_n, 3) == 1'b0)
      else $error("manual glitch passed");

   chk_sup_glitch_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_q == SRSUP_RUN && $rose(sup_low_f)) |->
      $past(in_w.supply_low, 3) == 1'b1)
      else $error("supply glitch passed");

   chk_manual_delay: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (!in_w.manual_reset_n) [*6] |=> !mr_n_f)
      else $error("held manual low did not pass the filter");

   // checks on the trip level
   chk_trip_range: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $past(i_rst_n) |-> o_trip_level >= TRIP_FLOOR && o_trip_level <= TRIP_CEIL)
      else $error("trip level out of range");

   chk_trip_stable: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ($past(i_rst_n) && $past(i_rst_n, 2)) |-> $stable(o_trip_level))
      else $error("trip level changed in operation");
endmodule

// ### test/srsup_cpu_model.sv
// processor reset input that listens to the supervisor's reset pin
`timescale 1ns/1ps
module srsup_cpu_model (
   input wire logic i_reset,
   input wire logic i_reset_oe,
   output logic o_in_reset
);
   // pin pulled up when released, so parallel supervisors can share it
   wire pin_level = i_reset_oe ? i_reset : 1'b1;
   assign o_in_reset = ~pin_level;
endmodule

// ### test/test_srsup_top.sv
// testbench for the supply reset supervisor
`timescale 1ns/1ps
module test_srsup_top;
   import srsup_pkg::*;
   localparam int unsigned HOLD = 50;
   logic i_ref_clk, i_rst_n, i_supply_low, i_manual_reset_n;
   logic pp_reset, pp_oe, od_reset, od_oe, od_seen;
   logic [8:0] trip;
   int miscompares = 0;
   int checks = 0;
   int n;
   initial begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end
   srsup_top #(.HOLD_CYCLES(HOLD)) uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_supply_low(i_supply_low), .i_manual_reset_n(i_manual_reset_n),
      .o_reset(pp_reset), .o_reset_oe(pp_oe), .o_trip_level(trip));
   srsup_top #(.OPEN_DRAIN(1'b1), .HOLD_CYCLES(HOLD)) uut_od (.i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n), .i_supply_low(i_supply_low), .i_manual_reset_n(i_manual_reset_n),
      .o_reset(od_reset), .o_reset_oe(od_oe), .o_trip_level());
   srsup_cpu_model cpu (.i_reset(od_reset), .i_reset_oe(od_oe), .o_in_reset(od_seen));
   task check(input string what, input logic [8:0] exp, input logic [8:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_cyc(input int c);
      repeat (c) @(posedge i_ref_clk);
      #1;
   endtask
   task expect_rst(input logic on);
      check("push-pull reset", 9'(!on), 9'(pp_reset));
      check("push-pull enable", 9'h001, 9'(pp_oe));
      check("open-drain enable", 9'(on), 9'(od_oe));
      check("open-drain data", 9'h000, 9'(od_reset));
      check("shared pin reset", 9'(on), 9'(od_seen));
   endtask
   task wait_release(input int lim);
      n = 0;
      while (pp_reset !== 1'b1 && n < lim) begin
         wait_cyc(1);
         n++;
      end
   endtask
   task check_span(input string what, input int lo, input int hi);
      check(what, 9'h001, 9'(n >= lo && n <= hi));
   endtask
   task t_power_up();
      expect_rst(1'b1);
      check("trip level", TRIP_MID, trip);
      wait_release(800);
      check_span("power-up hold", SUP_FILT_CYC + HOLD, SUP_FILT_CYC + HOLD + 20);
      expect_rst(1'b0);
      $display("done power_up");
   endtask
   task t_manual_glitch();
      i_manual_reset_n = 1'b0;
      wait_cyc(2);
      i_manual_reset_n = 1'b1;
      repeat (20) begin
         wait_cyc(1);
         expect_rst(1'b0);
      end
      $display("done manual_glitch");
   endtask
   task t_manual_press();
      // held 250 cycles, which is the guaranteed 10 us
      i_manual_reset_n = 1'b0;
      wait_cyc(10);
      expect_rst(1'b1);
      repeat (240) begin
         wait_cyc(1);
         expect_rst(1'b1);
      end
      i_manual_reset_n = 1'b1;
      wait_release(100);
      check_span("manual hold", HOLD, HOLD + 20);
      $display("done manual_press");
   endtask
   task t_restart();
      i_manual_reset_n = 1'b0;
      wait_cyc(20);
      i_manual_reset_n = 1'b1;
      wait_cyc(30);
      expect_rst(1'b1);
      i_manual_reset_n = 1'b0;
      wait_cyc(20);
      i_manual_reset_n = 1'b1;
      wait_release(100);
      check_span("restarted hold", HOLD, HOLD + 20);
      $display("done restart");
   endtask
   task t_supply_glitch();
      // 420 cycles high is shorter than the supply filter time
      i_supply_low = 1'b1;
      repeat (420) begin
         wait_cyc(1);
         expect_rst(1'b0);
      end
      i_supply_low = 1'b0;
      repeat (20) begin
         wait_cyc(1);
         expect_rst(1'b0);
      end
      $display("done supply_glitch");
   endtask
   task t_brownout();
      i_supply_low = 1'b1;
      wait_cyc(520);
      expect_rst(1'b1);
      wait_cyc(100);
      i_supply_low = 1'b0;
      wait_release(800);
      check_span("brownout hold", SUP_FILT_CYC + HOLD, SUP_FILT_CYC + HOLD + 20);
      $display("done brownout");
   endtask
   task complete_run();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      i_rst_n = 1'b0;
      i_supply_low = 1'b0;
      i_manual_reset_n = 1'b1;
      n = 0;
      wait_cyc(2);
      i_rst_n = 1'b1;
      wait_cyc(1);
      t_power_up();
      t_manual_glitch();
      t_manual_press();
      t_restart();
      t_supply_glitch();
      t_brownout();
      complete_run();
   end
   initial begin
      wait_cyc(10000);
      miscompares++;
      complete_run();
   end
endmodule
